// ===== src/mrm_map.svh
// Purpose: offsets, fields, reset values and timing for mode/map control
// Assumes: 32-bit AXI4-Lite data, register byte address = 4 * index
// Notes: included by the decoder and top design files of the block
//
// Summary of operation
// - mode pins are caught at reset release into special, B and A bits
// - special bit writable only while zero; first write after reset ignored
// - B/A bits: once when special bit one, anytime when zero; no peripheral
// - stretch off: E runs free; on: high on external, low on hidden internal
// - clock stretch enable reads one in every expanded mode
// - clock stretch enable: once in normal modes, anytime in special modes
// - visibility in special narrow shows internal cycles in wide format
// - visibility drives internal activity out in expanded modes; ignored in normal narrow
// - visibility and port E emulation: once normal; special skips first
// - bus wait-stop shuts external bus in wait after a drain delay
// - port E emulation in expanded mode sends port E registers external
// - mode register leaves the internal map in peripheral mode
// - position registers: once in normal modes, anytime in special modes
// - new mapping acts within two cycles after the write
// - overlap priority: debug ROM, registers, RAM, EEPROM, flash
// - in expanded modes unclaimed addresses are external accesses
// - register block: first 512 bytes of a 2K region, bits 15..11
// - RAM: first 512 bytes of a 2K region, reset at 0x0800
// - map wait-stop shuts the mapping interface during wait mode
// - active debug maps ROM at FF00-FFFF, control at FF00-FF06
// - special single chip starts with debug enabled and active
// - debug accesses use dead bus cycles; none in peripheral mode
// - mode encoding 000..111 as listed, 110 forced to peripheral
`ifndef MRM_MAP_SVH
`define MRM_MAP_SVH

// ----------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------
`define MRM_IDX_MODE 8'h0b
`define MRM_IDX_RAMPOS 8'h10
`define MRM_IDX_REGPOS 8'h11
`define MRM_IDX_DBGSTAT 8'h20
`define MRM_BYTE(i) ({i, 2'b00})

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define MRM_F_SPECIAL_MODE_NOT 7
`define MRM_F_MODE_SELECT_B 6
`define MRM_F_MODE_SELECT_A 5
`define MRM_F_BUS_CLOCK_STRETCH_ENABLE 4
`define MRM_F_INTERNAL_VISIBILITY 3
`define MRM_F_EXT_BUS_WAIT_STOP 2
`define MRM_F_EME 0
`define MRM_F_MAP_IFACE_WAIT_STOP 0
`define MRM_RAMPOS_RST 5'h01
`define MRM_REGPOS_RST 5'h00
`define MRM_PORT_E_DATA_REG_OFS 9'h008
`define MRM_PORT_E_DIRECTION_REG_OFS 9'h009
`define MRM_DBG_HI 8'hff
`define MRM_DBG_CTL_LAST 8'h06
`define MRM_RESP_OKAY 2'h0
`define MRM_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MRM_CLK_NS 50
`define MRM_DRAIN_NS 200
`define MRM_DRAIN_CYC ((`MRM_DRAIN_NS + `MRM_CLK_NS - 1) / `MRM_CLK_NS)

`endif

// ===== src/mrm_pkg.sv
// Purpose: types shared by the mode/map control modules
// Assumes: nothing
// Notes: constants live in mrm_map.svh
package mrm_pkg;

  // operating modes from the latched bits
  typedef enum logic [2:0] {
    MRM_SPEC_SINGLE = 3'b000,
    MRM_SPEC_NARROW = 3'b001,
    MRM_SPEC_PERIPH = 3'b010,
    MRM_SPEC_WIDE = 3'b011,
    MRM_NORM_SINGLE = 3'b100,
    MRM_NORM_NARROW = 3'b101,
    MRM_FORCED_PERIPH = 3'b110,
    MRM_NORM_WIDE = 3'b111
  } mrm_mode_t;

  // decoded target of an address
  typedef enum logic [2:0] {
    MRM_T_NONE = 3'b000,
    MRM_T_DBGROM = 3'b001,
    MRM_T_REGS = 3'b010,
    MRM_T_RAM = 3'b011,
    MRM_T_EEPROM = 3'b100,
    MRM_T_FLASH = 3'b101,
    MRM_T_EXT = 3'b110
  } mrm_target_t;

endpackage

// ===== src/mrm_map_if.sv
// Purpose: carries map settings to the decoder and its answer back
// Assumes: one clock, decoder is combinational
// Notes: ctl side is the control top, dec side the decoder
`timescale 1ns/1ps
interface mrm_map_if;
  logic [4:0] reg_pos;
  logic [4:0] ram_pos;
  logic dbg_active;
  logic expanded;
  logic peripheral;
  logic port_e_emulation;
  logic eeprom_hit;
  logic flash_hit;
  logic [15:0] addr;
  mrm_pkg::mrm_target_t target;
  logic dbg_ctl_hit;
  modport ctl (output reg_pos, ram_pos, dbg_active, expanded, peripheral,
    port_e_emulation, eeprom_hit, flash_hit, addr, input target, dbg_ctl_hit);
  modport dec (input reg_pos, ram_pos, dbg_active, expanded, peripheral,
    port_e_emulation, eeprom_hit, flash_hit, addr, output target, dbg_ctl_hit);
endinterface

// ===== src/mrm_decoder.sv
// Purpose: resolves an address to one internal resource or external
// Assumes: position values are already the effective copies
// Notes: purely combinational
`timescale 1ns/1ps
`include "mrm_map.svh"
module mrm_decoder (
  // map settings and answer
  mrm_map_if.dec m
);

  logic rom_hit;
  logic reg_hit;
  logic ram_hit;
  logic pe_out;
  logic per_out;

  // -------------------------------------------------------------
  // address decode with fixed precedence
  // -------------------------------------------------------------
  always_comb
  begin
    rom_hit = m.dbg_active && (m.addr[15:8] == `MRM_DBG_HI);
    reg_hit = (m.addr[15:11] == m.reg_pos) &&
      (m.addr[10:9] == 2'b00);
    ram_hit = (m.addr[15:11] == m.ram_pos) &&
      (m.addr[10:9] == 2'b00);
    // port E registers leave the map when emulated externally
    pe_out = m.expanded && m.port_e_emulation &&
      ((m.addr[8:0] == `MRM_PORT_E_DATA_REG_OFS) ||
      (m.addr[8:0] == `MRM_PORT_E_DIRECTION_REG_OFS));
    // bus expansion registers, mode register among them, leave the map
    per_out = m.peripheral && (m.addr[8:4] == 5'h00);
    m.dbg_ctl_hit = rom_hit && (m.addr[7:0] <= `MRM_DBG_CTL_LAST);
    if (rom_hit)
      m.target = mrm_pkg::MRM_T_DBGROM;
    else if (reg_hit && !pe_out && !per_out)
      m.target = mrm_pkg::MRM_T_REGS;
    else if (reg_hit)
      m.target = m.expanded ? mrm_pkg::MRM_T_EXT : mrm_pkg::MRM_T_NONE;
    else if (ram_hit)
      m.target = mrm_pkg::MRM_T_RAM;
    else if (m.eeprom_hit)
      m.target = mrm_pkg::MRM_T_EEPROM;
    else if (m.flash_hit)
      m.target = mrm_pkg::MRM_T_FLASH;
    else if (m.expanded)
      m.target = mrm_pkg::MRM_T_EXT;
    else
      m.target = mrm_pkg::MRM_T_NONE;
  end

endmodule // mrm_decoder

// ===== src/mrm_top.sv
// Purpose: mode register, resource position registers, E clock,
//   visibility, wait shutdown and debug ROM mapping behind AXI4-Lite
// Assumes: master keeps AW and W valid until taken
// Notes: mode pins pass a two-stage synchroniser before capture
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "mrm_map.svh"
module mrm_top #(
  parameter int DRAIN_CYC = `MRM_DRAIN_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // mode select pins
  input wire logic debug_serial_pin,
  input wire logic mode_select_b,
  input wire logic mode_select_a,
  // cpu bus cycle
  input wire logic cpu_valid,
  input wire logic [15:0] cpu_addr,
  input wire logic wait_mode,
  input wire logic eeprom_hit,
  input wire logic flash_hit,
  // debug control
  input wire logic dbg_enable_cmd,
  input wire logic dbg_go_cmd,
  input wire logic enter_debug_instruction,
  input wire logic dbg_exit_cmd,
  input wire logic dbg_acc_req,
  input wire logic dbg_acc_write,
  input wire logic [15:0] dbg_acc_addr,
  // status and bus control outputs
  output logic [2:0] mode_r,
  output mrm_pkg::mrm_target_t target_r,
  output logic dbg_ctl_sel_r,
  output logic dbg_active_r,
  output logic dbg_acc_grant_r,
  output logic e_clk_r,
  output logic vis_drive_r,
  output logic vis_wide_r,
  output logic ext_bus_off_r,
  output logic map_off_r
);

  localparam int CW = $clog2(DRAIN_CYC + 1);

  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  logic arm_r;
  logic special_mode_not_r, mode_select_b_r, mode_select_a_r;
  logic bus_clock_stretch_enable_r, internal_visibility_r, ext_bus_wait_stop_r, eme_r;
  logic first_wr_r, mode_lock_r;
  logic [4:0] ram_pos_r, reg_pos_r, ram_eff_r, reg_eff_r;
  logic map_iface_wait_stop_r, ram_lock_r, reg_lock_r;
  logic dbg_en_r;
  logic awready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [CW-1:0] drain_r;
  logic special, expanded, periph, vis_ok, internal, wr_en;
  logic [7:0] mode_rd, wbyte;
  mrm_map_if m ();

  // -------------------------------------------------------------
  // mode decode and decoder hookup
  // -------------------------------------------------------------
  assign mode_r = {special_mode_not_r, mode_select_b_r, mode_select_a_r};
  assign special = !special_mode_not_r;
  assign expanded = mode_select_a_r;
  assign periph = mode_select_b_r && !mode_select_a_r;
  assign vis_ok = internal_visibility_r && expanded &&
    (mode_r != mrm_pkg::MRM_NORM_NARROW);
  assign mode_rd = {special_mode_not_r, mode_select_b_r, mode_select_a_r, bus_clock_stretch_enable_r | expanded,
    internal_visibility_r, ext_bus_wait_stop_r, 1'b0, eme_r};
  assign wbyte = s_axi_wdata[7:0];
  assign wr_en = awready_r && s_axi_wstrb[0];
  assign m.reg_pos = reg_eff_r;
  assign m.ram_pos = ram_eff_r;
  assign m.dbg_active = dbg_active_r;
  assign m.expanded = expanded;
  assign m.peripheral = periph;
  assign m.port_e_emulation = eme_r;
  assign m.eeprom_hit = eeprom_hit;
  assign m.flash_hit = flash_hit;
  assign m.addr = cpu_valid ? cpu_addr : dbg_acc_addr;
  assign internal = (m.target != mrm_pkg::MRM_T_NONE) &&
    (m.target != mrm_pkg::MRM_T_EXT);

  mrm_decoder u_dec (
    .m(m)
  );

  // -------------------------------------------------------------
  // mode pin synchroniser (no reset: must hold pin levels)
  // -------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    pin_s1_r <= {debug_serial_pin, mode_select_b, mode_select_a};
    pin_s2_r <= pin_s1_r;
  end

  // -------------------------------------------------------------
  // mode register: capture at reset release, guarded writes
  // -------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arm_r <= 1'b1;
      {special_mode_not_r, mode_select_b_r, mode_select_a_r} <= 3'h4;
      bus_clock_stretch_enable_r <= 1'b1;
      internal_visibility_r <= 1'b0;
      ext_bus_wait_stop_r <= 1'b0;
      eme_r <= 1'b0;
      first_wr_r <= 1'b0;
      mode_lock_r <= 1'b0;
    end
    else if (arm_r)
    begin
      arm_r <= 1'b0;
      {special_mode_not_r, mode_select_b_r, mode_select_a_r} <= pin_s2_r;
      bus_clock_stretch_enable_r <= 1'b1;
      internal_visibility_r <= !pin_s2_r[2];
      eme_r <= !pin_s2_r[2];
    end
    else if (wr_en && s_axi_awaddr == `MRM_BYTE(`MRM_IDX_MODE) && !periph)
    begin
      first_wr_r <= 1'b1;
      if (!special)
        mode_lock_r <= 1'b1;
      if (special && first_wr_r)
        special_mode_not_r <= wbyte[`MRM_F_SPECIAL_MODE_NOT];
      if ((special || !mode_lock_r) &&
        !(wbyte[`MRM_F_MODE_SELECT_B] && !wbyte[`MRM_F_MODE_SELECT_A]))
      begin
        mode_select_b_r <= wbyte[`MRM_F_MODE_SELECT_B];
        mode_select_a_r <= wbyte[`MRM_F_MODE_SELECT_A];
      end
      if (special || !mode_lock_r)
        bus_clock_stretch_enable_r <= wbyte[`MRM_F_BUS_CLOCK_STRETCH_ENABLE];
      if (special ? first_wr_r : !mode_lock_r)
      begin
        internal_visibility_r <= wbyte[`MRM_F_INTERNAL_VISIBILITY];
        eme_r <= wbyte[`MRM_F_EME];
      end
      ext_bus_wait_stop_r <= wbyte[`MRM_F_EXT_BUS_WAIT_STOP];
    end
  end

  // -------------------------------------------------------------
  // position registers and their delayed effective copies
  // -------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ram_pos_r <= `MRM_RAMPOS_RST;
      reg_pos_r <= `MRM_REGPOS_RST;
      map_iface_wait_stop_r <= 1'b0;
      ram_lock_r <= 1'b0;
      reg_lock_r <= 1'b0;
    end
    else if (wr_en && s_axi_awaddr == `MRM_BYTE(`MRM_IDX_RAMPOS))
    begin
      if (special || !ram_lock_r)
        ram_pos_r <= wbyte[7:3];
      if (!special)
        ram_lock_r <= 1'b1;
    end
    else if (wr_en && s_axi_awaddr == `MRM_BYTE(`MRM_IDX_REGPOS))
    begin
      if (special || !reg_lock_r)
      begin
        reg_pos_r <= wbyte[7:3];
        map_iface_wait_stop_r <= wbyte[`MRM_F_MAP_IFACE_WAIT_STOP];
      end
      if (!special)
        reg_lock_r <= 1'b1;
    end
  end

  // new positions reach the decoder one cycle after they are stored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ram_eff_r <= `MRM_RAMPOS_RST;
      reg_eff_r <= `MRM_REGPOS_RST;
    end
    else
    begin
      ram_eff_r <= ram_pos_r;
      reg_eff_r <= reg_pos_r;
    end
  end

  // -------------------------------------------------------------
  // axi4-lite write channel: aw and w taken together
  // -------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `MRM_RESP_OKAY;
    end
    else if (awready_r)
    begin
      awready_r <= 1'b0;
      bvalid_r <= 1'b1;
      if (s_axi_awaddr == `MRM_BYTE(`MRM_IDX_MODE))
        bresp_r <= periph ? `MRM_RESP_SLVERR : `MRM_RESP_OKAY;
      else if (s_axi_awaddr == `MRM_BYTE(`MRM_IDX_RAMPOS))
        bresp_r <= `MRM_RESP_OKAY;
      else if (s_axi_awaddr == `MRM_BYTE(`MRM_IDX_REGPOS))
        bresp_r <= `MRM_RESP_OKAY;
      else
        bresp_r <= `MRM_RESP_SLVERR;
    end
    else if (bvalid_r)
    begin
      if (s_axi_bready)
        bvalid_r <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_wvalid && !arm_r)
      awready_r <= 1'b1;
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = awready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // -------------------------------------------------------------
  // axi4-lite read channel
  // -------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `MRM_RESP_OKAY;
    end
    else if (arready_r)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= `MRM_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      if (s_axi_araddr == `MRM_BYTE(`MRM_IDX_MODE))
      begin
        if (periph)
          rresp_r <= `MRM_RESP_SLVERR;
        else
          rdata_r[7:0] <= mode_rd;
      end
      else if (s_axi_araddr == `MRM_BYTE(`MRM_IDX_RAMPOS))
        rdata_r[7:0] <= {ram_pos_r, 3'h0};
      else if (s_axi_araddr == `MRM_BYTE(`MRM_IDX_REGPOS))
        rdata_r[7:0] <= {reg_pos_r, 2'h0, map_iface_wait_stop_r};
      else if (s_axi_araddr == `MRM_BYTE(`MRM_IDX_DBGSTAT))
        rdata_r[3:0] <= {map_off_r, ext_bus_off_r, dbg_active_r, dbg_en_r};
      else
        rresp_r <= `MRM_RESP_SLVERR;
    end
    else if (rvalid_r)
    begin
      if (s_axi_rready)
        rvalid_r <= 1'b0;
    end
    else if (s_axi_arvalid && !arm_r)
      arready_r <= 1'b1;
  end

  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // -------------------------------------------------------------
  // debug enable and activation
  // -------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dbg_en_r <= 1'b0;
      dbg_active_r <= 1'b0;
    end
    else if (arm_r)
    begin
      dbg_en_r <= (pin_s2_r == mrm_pkg::MRM_SPEC_SINGLE);
      dbg_active_r <= (pin_s2_r == mrm_pkg::MRM_SPEC_SINGLE);
    end
    else
    begin
      if (dbg_enable_cmd)
        dbg_en_r <= 1'b1;
      if (dbg_exit_cmd)
        dbg_active_r <= 1'b0;
      else if (dbg_en_r && (dbg_go_cmd || enter_debug_instruction))
        dbg_active_r <= 1'b1;
    end
  end

  // -------------------------------------------------------------
  // decoded target, debug access grant on dead bus cycles
  // -------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      target_r <= mrm_pkg::MRM_T_NONE;
      dbg_ctl_sel_r <= 1'b0;
      dbg_acc_grant_r <= 1'b0;
    end
    else
    begin
      target_r <= (cpu_valid && !map_off_r) ? m.target :
        mrm_pkg::MRM_T_NONE;
      dbg_ctl_sel_r <= cpu_valid && !map_off_r && m.dbg_ctl_hit;
      dbg_acc_grant_r <= !cpu_valid && dbg_acc_req && !periph &&
        ((m.target == mrm_pkg::MRM_T_REGS) ||
        (m.target == mrm_pkg::MRM_T_RAM) ||
        (!dbg_acc_write && ((m.target == mrm_pkg::MRM_T_EEPROM) ||
        (m.target == mrm_pkg::MRM_T_FLASH))));
    end
  end

  // -------------------------------------------------------------
  // E clock and internal visibility
  // -------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      e_clk_r <= 1'b0;
      vis_drive_r <= 1'b0;
      vis_wide_r <= 1'b0;
    end
    else
    begin
      if (!mode_rd[`MRM_F_BUS_CLOCK_STRETCH_ENABLE])
        e_clk_r <= !e_clk_r;
      else if (cpu_valid && m.target == mrm_pkg::MRM_T_EXT)
        e_clk_r <= 1'b1;
      else if (cpu_valid && internal && !vis_ok)
        e_clk_r <= 1'b0;
      else
        e_clk_r <= !e_clk_r;
      vis_drive_r <= cpu_valid && internal && vis_ok;
      vis_wide_r <= cpu_valid && internal && vis_ok &&
        (mode_r == mrm_pkg::MRM_SPEC_NARROW);
    end
  end

  // -------------------------------------------------------------
  // wait-mode shutdown: bus after drain delay, map at once
  // -------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      drain_r <= '0;
      ext_bus_off_r <= 1'b0;
      map_off_r <= 1'b0;
    end
    else
    begin
      if (!(wait_mode && ext_bus_wait_stop_r))
        drain_r <= '0;
      else if (drain_r != CW'(DRAIN_CYC))
        drain_r <= drain_r + 1'b1;
      ext_bus_off_r <= wait_mode && ext_bus_wait_stop_r &&
        (drain_r == CW'(DRAIN_CYC));
      map_off_r <= wait_mode && map_iface_wait_stop_r;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  special_mode_not_hold_a: assert property (
    (!arm_r && special_mode_not_r) |=> special_mode_not_r)
    else $error("special bit cleared after being one");
  no_periph_a: assert property (
    (!arm_r && !periph) |=> !periph)
    else $error("peripheral mode entered by a write");
  bus_clock_stretch_enable_exp_a: assert property (
    (!arm_r && expanded) |-> mode_rd[`MRM_F_BUS_CLOCK_STRETCH_ENABLE])
    else $error("stretch enable reads zero in expanded mode");
  pos_once_a: assert property (
    (!arm_r && !special && ram_lock_r) |=> $stable(ram_pos_r))
    else $error("ram position changed after its one write");
  map_delay_a: assert property (
    (wr_en && special && s_axi_awaddr == `MRM_BYTE(`MRM_IDX_RAMPOS))
    |-> ##2 (ram_eff_r == ram_pos_r))
    else $error("ram mapping not in effect two cycles after write");
  dbg_rom_a: assert property (
    (dbg_active_r && cpu_valid && !map_off_r &&
    cpu_addr[15:8] == `MRM_DBG_HI)
    |=> target_r == mrm_pkg::MRM_T_DBGROM)
    else $error("debug rom lost priority");
  ext_only_a: assert property (
    (target_r == mrm_pkg::MRM_T_EXT) |-> $past(expanded))
    else $error("external access outside expanded mode");
  drain_wait_a: assert property (
    $rose(ext_bus_off_r) |-> $past(drain_r) == CW'(DRAIN_CYC))
    else $error("external bus shut without drain delay");
  ssc_debug_a: assert property (
    (arm_r && pin_s2_r == 3'h0) |=> (dbg_active_r && dbg_en_r))
    else $error("special single chip did not start in debug");

endmodule // mrm_top

// ===== test/mrm_ext_mem.sv
// Purpose: far-side model, external memory on the multiplexed bus
// Assumes: a cycle decoded external is one external memory access
// Notes: counts accesses that it saw with E high
`timescale 1ns/1ps
module mrm_ext_mem (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus control from the block
  input mrm_pkg::mrm_target_t target_r,
  input wire logic e_clk_r,
  // access count
  output int ext_cycles
);
  // count external cycles; memory only responds while E is high
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ext_cycles <= 0;
    else if (target_r == mrm_pkg::MRM_T_EXT && e_clk_r)
      ext_cycles <= ext_cycles + 1;
  end
endmodule // mrm_ext_mem

// ===== test/mode_and_resource_map_control_tb_top.sv
// Purpose: register, decode and debug map checks over AXI4-Lite
// Assumes: byte address is four times the register index
// Notes: three resets: normal expanded narrow, special single chip,
//   then special expanded narrow
`timescale 1ns/1ps
module mode_and_resource_map_control_tb_top;
  logic aclk = 0, aresetn = 0;
  logic [9:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [2:0] pins = 0;
  logic cv = 0, wt = 0, eh = 0, fh = 0, ex = 0;
  logic [15:0] ca = 0;
  logic [2:0] mode;
  mrm_pkg::mrm_target_t tgt;
  logic csel, dact, ecl, moff;
  logic en = 0, go = 0, rq = 0;
  logic gnt, vd, vw, eoff;
  int err_count = 0, comparisons = 0, ext_cycles;
  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  mrm_top #(.DRAIN_CYC(1)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .debug_serial_pin(pins[2]), .mode_select_b(pins[1]),
    .mode_select_a(pins[0]), .cpu_valid(cv), .cpu_addr(ca), .wait_mode(wt),
    .eeprom_hit(eh), .flash_hit(fh), .dbg_enable_cmd(en),
    .dbg_go_cmd(go), .enter_debug_instruction(1'b0), .dbg_exit_cmd(ex),
    .dbg_acc_req(rq), .dbg_acc_write(1'b0), .dbg_acc_addr(16'h0000),
    .mode_r(mode), .target_r(tgt), .dbg_ctl_sel_r(csel),
    .dbg_active_r(dact), .dbg_acc_grant_r(gnt), .e_clk_r(ecl),
    .vis_drive_r(vd), .vis_wide_r(vw), .ext_bus_off_r(eoff),
    .map_off_r(moff));
  mrm_ext_mem mem_u (.aclk(aclk), .aresetn(aresetn), .target_r(tgt),
    .e_clk_r(ecl), .ext_cycles(ext_cycles));
  // clock, 50 ns period
  initial
  begin
    forever #25 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rst(input logic [2:0] p);
    aresetn <= 0;
    pins <= p;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
  endtask
  // write one byte; each channel released once taken
  task automatic wr(input logic [9:0] a, input logic [7:0] d,
    input logic [1:0] er);
    logic aw, w;
    aw = 1;
    w = 1;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (aw || w)
    begin
      @(posedge aclk);
      if (aw && awready === 1'b1)
      begin
        aw = 0;
        awvalid <= 0;
      end
      if (w && wready === 1'b1)
      begin
        w = 0;
        wvalid <= 0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    chk(bresp, er);
    bready <= 0;
    // let an edge pass so the next call does not re-raise bready at once
    @(posedge aclk);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] d,
    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    chk(rresp, er);
    chk(rdata, {24'h000000, d});
    rready <= 0;
    // let an edge pass so the next call does not re-raise rready at once
    @(posedge aclk);
  endtask
  // hold a cpu cycle, then check the decoded target
  task automatic dec(input logic [15:0] a, input logic [2:0] t);
    cv <= 1;
    ca <= a;
    repeat (3) @(posedge aclk);
    chk(tgt, t);
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5000) @(posedge aclk);
    err_count++;
    end_sim();
  end
  initial
  begin
    rst(3'b101);
    chk(mode, 3'b101);
    rd(10'h02c, 8'hb0, 2'h0);
    rd(10'h040, 8'h08, 2'h0);
    rd(10'h044, 8'h00, 2'h0);
    rd(10'h3fc, 8'h00, 2'h2);
    wr(10'h040, 8'h20, 2'h0);
    wr(10'h040, 8'h30, 2'h0);
    rd(10'h040, 8'h20, 2'h0);
    dec(16'h2000, 3'd3);
    dec(16'h0010, 3'd2);
    dec(16'h2200, 3'd6);
    chk(ecl, 1'b1);
    chk(ext_cycles > 0, 1'b1);
    wr(10'h02c, 8'hc0, 2'h0);
    rd(10'h02c, 8'hb0, 2'h0);
    cv <= 0;
    rq <= 1;
    repeat (2) @(posedge aclk);
    chk(gnt, 1'b1);
    cv <= 1;
    repeat (2) @(posedge aclk);
    chk(gnt, 1'b0);
    rq <= 0;
    en <= 1;
    @(posedge aclk);
    en <= 0;
    go <= 1;
    @(posedge aclk);
    go <= 0;
    @(posedge aclk);
    chk(dact, 1'b1);
    $display("test normal expanded narrow done");
    rst(3'b000);
    rd(10'h02c, 8'h19, 2'h0);
    chk(dact, 1'b1);
    rd(10'h080, 8'h03, 2'h0);
    dec(16'hff03, 3'd1);
    chk(csel, 1'b1);
    eh <= 1;
    fh <= 1;
    dec(16'h4000, 3'd4);
    eh <= 0;
    dec(16'h4000, 3'd5);
    fh <= 0;
    wr(10'h040, 8'h10, 2'h0);
    wr(10'h040, 8'h18, 2'h0);
    rd(10'h040, 8'h18, 2'h0);
    ex <= 1;
    @(posedge aclk);
    ex <= 0;
    dec(16'hff03, 3'd0);
    wr(10'h02c, 8'h84, 2'h0);
    rd(10'h02c, 8'h0d, 2'h0);
    wr(10'h044, 8'h01, 2'h0);
    wt <= 1;
    repeat (3) @(posedge aclk);
    chk(moff, 1'b1);
    chk(eoff, 1'b1);
    wt <= 0;
    repeat (3) @(posedge aclk);
    chk(moff, 1'b0);
    chk(eoff, 1'b0);
    $display("test special single chip done");
    rst(3'b001);
    rd(10'h02c, 8'h39, 2'h0);
    dec(16'h0010, 3'd2);
    chk(vd, 1'b1);
    chk(vw, 1'b1);
    dec(16'h0008, 3'd6);
    $display("test special expanded narrow done");
    end_sim();
  end
endmodule // mode_and_resource_map_control_tb_top
